/* core/usbef_pkg.sv */
// Shared constants and types for the endpoint FIFO and status block.
package usbef_pkg;
    localparam int EP_COUNT = 7;
    localparam int COUNT_W = 11;
    localparam int STORE_AW = 11;
    // Register word indices; the byte address is four times the index.
    localparam logic [3:0] REG_EP_SELECT = 4'h0;
    localparam logic [3:0] REG_EP_CONFIG = 4'h1;
    localparam logic [3:0] REG_BANK_STATUS = 4'h2;
    localparam logic [3:0] REG_BANK_AUX = 4'h3;
    localparam logic [3:0] REG_EVENT_FLAGS = 4'h4;
    localparam logic [3:0] REG_EVENT_ENABLES = 4'h5;
    localparam logic [3:0] REG_FIFO_DATA = 4'h6;
    localparam logic [3:0] REG_COUNT_HIGH = 4'h7;
    localparam logic [3:0] REG_COUNT_LOW = 4'h8;
    localparam logic [3:0] REG_PENDING = 4'h9;
    // Event flag positions.
    localparam int FLAG_BANK_RELEASE = 7;
    localparam int FLAG_NAK_IN = 6;
    localparam int FLAG_RW_ALLOWED = 5;
    localparam int FLAG_NAK_OUT = 4;
    localparam int FLAG_SETUP = 3;
    localparam int FLAG_OUT_RX = 2;
    localparam int FLAG_STALLED = 1;
    localparam int FLAG_TX_READY = 0;
    localparam int EN_FLOW_ERROR = 7;
    // Configuration and status field positions.
    localparam int CFG_DIR_IN = 0;
    localparam int CFG_DOUBLE = 2;
    localparam int CFG_STALL_REQ = 5;
    localparam int CFG_TYPE_LO = 6;
    localparam int STAT_OVERFLOW = 6;
    localparam int STAT_UNDERFLOW = 5;
    localparam int AUX_CTRL_DIR = 2;
    // Masks and reset values.
    localparam logic [7:0] EVENT_MASK = 8'h5F;
    localparam logic [7:0] CLEARABLE = 8'hDB;
    localparam logic [7:0] ENABLE_MASK = 8'hDF;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] ENABLES_RESET = 8'h00;
    localparam logic [2:0] SELECT_RESET = 3'h0;
    localparam logic [1:0] BUSY_NONE = 2'h0;
    localparam logic [1:0] BUSY_RESERVED = 2'h3;
    typedef enum logic [1:0] {
        EP_CONTROL = 2'b00,
        EP_ISO = 2'b01,
        EP_BULK = 2'b10,
        EP_INTR = 2'b11
    } usbef_type_t;
endpackage : usbef_pkg

/* core/usbef_byte_store.sv */
// Shared byte memory holding every endpoint's FIFO contents.
`timescale 1ns/1ps
`default_nettype none
module usbef_byte_store
    import usbef_pkg::*;
(
    input wire logic mclk,
    input wire logic wrEnA,
    input wire logic [STORE_AW-1:0] wrAddrA,
    input wire logic [7:0] wrDataA,
    input wire logic wrEnB,
    input wire logic [STORE_AW-1:0] wrAddrB,
    input wire logic [7:0] wrDataB,
    input wire logic [STORE_AW-1:0] rdAddrA,
    output logic [7:0] rdDataA,
    input wire logic [STORE_AW-1:0] rdAddrB,
    output logic [7:0] rdDataB
);
    logic [7:0] mem [2**STORE_AW];

    // Port B wins a same-address collision; directions keep them apart.
    always_ff @(posedge mclk)
    begin
        if (wrEnA)
        begin
            mem[wrAddrA] <= wrDataA;
        end
        if (wrEnB)
        begin
            mem[wrAddrB] <= wrDataB;
        end
    end

    assign rdDataA = mem[rdAddrA];
    assign rdDataB = mem[rdAddrB];
endmodule : usbef_byte_store
`default_nettype wire

/* core/usbef_byte_counter.sv */
// Up/down byte counter for one endpoint FIFO.
`timescale 1ns/1ps
`default_nettype none
module usbef_byte_counter
    import usbef_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic countUp,
    input wire logic countDown,
    output logic [COUNT_W-1:0] count
);
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            count <= '0;
        end
        else if (countUp && !countDown)
        begin
            count <= count + COUNT_W'(1);
        end
        else if (countDown && !countUp)
        begin
            count <= count - COUNT_W'(1);
        end
    end
endmodule : usbef_byte_counter
`default_nettype wire

/* core/usbef_endpoint.sv */
// Endpoint bank, event flag and FIFO logic behind a Wishbone slave.
// Function
// - Busy-bank count is two bits: none, one or two busy; 11 never shown.
// - IN counts firmware-filled banks; OUT counts host-filled banks.
// - SETUP latches read-only control direction of next packet, 1 is IN.
// - Current bank index reads 00 or 01, read-only.
// - OUT/SETUP: release bit sets with receive flag; clearing frees bank.
// - IN: release bit sets with tx-ready; clearing sends bank, switches.
// - NAK sent to IN sets sticky nak-in flag, software clears.
// - NAK sent to OUT or PING sets sticky nak-out flag.
// - Read/write allowed per bank state, never under stall or error.
// - New SETUP sets setup flag; always clear on IN endpoints.
// - New OUT packet sets out-received flag; writing one does nothing.
// - On IN, bit two kills last written bank; hardware clears it.
// - STALL sent or iso OUT CRC error sets stalled flag.
// - Free bank sets tx-ready flag; always clear on OUT endpoints.
// - Each event except bank release, read/write allowed and (on IN) out-received is gated into the endpoint interrupt by its enable; those never interrupt.
// - Byte data port reads or writes one FIFO byte per access.
// - Eleven-bit byte count split over high and low read-only registers.
// - Count follows firmware and host bytes according to direction.
// - One pending bit per endpoint while an enabled event is pending.
// - Reserved bits read zero; firmware writes them as zero.
// - Overflow and underflow flags set on isochronous flow errors.
//
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module usbef_endpoint
    import usbef_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [2:0] usbEp,
    input wire logic usbSetupDone,
    input wire logic usbSetupDirIn,
    input wire logic usbOutDone,
    input wire logic usbInTaken,
    input wire logic usbNakIn,
    input wire logic usbNakOut,
    input wire logic usbStallSent,
    input wire logic usbCrcErr,
    input wire logic usbOverflow,
    input wire logic usbUnderflow,
    input wire logic usbRxByte,
    input wire logic [7:0] usbRxData,
    input wire logic usbTxByte,
    output logic [7:0] usbTxData,
    output logic endpointIrq
);
    logic [2:0] epSel;
    logic [7:0] flags [EP_COUNT];
    logic [7:0] next_flags [EP_COUNT];
    logic [7:0] enables [EP_COUNT];
    logic [1:0] busy [EP_COUNT];
    logic [1:0] next_busy [EP_COUNT];
    logic curBank [EP_COUNT];
    logic next_curBank [EP_COUNT];
    logic cfgDirIn [EP_COUNT];
    logic cfgDouble [EP_COUNT];
    usbef_type_t cfgType [EP_COUNT];
    logic stallReq [EP_COUNT];
    logic control_direction_flag [EP_COUNT];
    logic overflow [EP_COUNT];
    logic underflow [EP_COUNT];
    logic [7:0] rdPtr [EP_COUNT];
    logic [7:0] wrPtr [EP_COUNT];
    logic [COUNT_W-1:0] count [EP_COUNT];
    logic [EP_COUNT-1:0] pending;
    logic [EP_COUNT-1:0] rwAllowed;
    logic req;
    logic wbDo;
    logic wbWr;
    logic [3:0] regIdx;
    logic fwDataWr;
    logic fwDataRd;
    logic evValid;
    logic [7:0] fwRdData;
    logic [7:0] txRdData;
    logic [31:0] next_rdata;

    assign req = wb_cyc_i && wb_stb_i;
    assign regIdx = wb_adr_i[5:2];
    // Effects land on the edge where the master samples the acknowledge.
    assign wbDo = req && wb_ack_o;
    assign wbWr = wbDo && wb_we_i && wb_sel_i[0];
    assign fwDataWr = wbWr && regIdx == REG_FIFO_DATA;
    assign fwDataRd = wbDo && !wb_we_i && regIdx == REG_FIFO_DATA;
    assign evValid = usbEp != 3'h7;

    function automatic logic hitEp(input logic [2:0] ep, input int e);
        hitEp = ep == 3'(e);
    endfunction : hitEp

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= req && !wb_ack_o;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            epSel <= SELECT_RESET;
        end
        else if (wbWr && regIdx == REG_EP_SELECT)
        begin
            epSel <= wb_dat_i[2:0];
        end
    end

    // Configuration, enables and the stall request of each endpoint.
    always_ff @(posedge mclk)
    begin
        for (int e = 0; e < EP_COUNT; e++)
        begin
            if (reset)
            begin
                cfgDirIn[e] <= 1'b0;
                cfgDouble[e] <= 1'b0;
                cfgType[e] <= EP_CONTROL;
                stallReq[e] <= 1'b0;
                enables[e] <= ENABLES_RESET;
            end
            else
            begin
                if (wbWr && hitEp(epSel, e) && regIdx == REG_EP_CONFIG)
                begin
                    cfgDirIn[e] <= wb_dat_i[CFG_DIR_IN];
                    cfgDouble[e] <= wb_dat_i[CFG_DOUBLE];
                    cfgType[e] <= usbef_type_t'(wb_dat_i[7:6]);
                    stallReq[e] <= wb_dat_i[CFG_STALL_REQ];
                end
                if (usbSetupDone && hitEp(usbEp, e))
                begin
                    stallReq[e] <= 1'b0;
                end
                if (wbWr && hitEp(epSel, e) && regIdx == REG_EVENT_ENABLES)
                begin
                    enables[e] <= wb_dat_i[7:0] & ENABLE_MASK;
                end
            end
        end
    end

    // Flow error and control direction status; a set beats a clear.
    always_ff @(posedge mclk)
    begin
        for (int e = 0; e < EP_COUNT; e++)
        begin
            if (reset)
            begin
                overflow[e] <= 1'b0;
                underflow[e] <= 1'b0;
                control_direction_flag[e] <= 1'b0;
            end
            else
            begin
                if (wbWr && hitEp(epSel, e) && regIdx == REG_BANK_STATUS)
                begin
                    overflow[e] <= overflow[e] && wb_dat_i[STAT_OVERFLOW];
                    underflow[e] <= underflow[e]
                        && wb_dat_i[STAT_UNDERFLOW];
                end
                if (hitEp(usbEp, e) && cfgType[e] == EP_ISO)
                begin
                    if (usbOverflow)
                    begin
                        overflow[e] <= 1'b1;
                    end
                    if (usbUnderflow)
                    begin
                        underflow[e] <= 1'b1;
                    end
                end
                if (usbSetupDone && hitEp(usbEp, e))
                begin
                    control_direction_flag[e] <= usbSetupDirIn;
                end
            end
        end
    end

    // Bank bookkeeping and event flags of every endpoint.
    always_comb
    begin
        for (int e = 0; e < EP_COUNT; e++)
        begin
            logic [7:0] clr;
            logic [7:0] set;
            logic [2:0] b3;
            logic swWr;
            logic hit;
            logic release_;
            logic killNow;
            logic dirNow;
            clr = 8'h00;
            set = 8'h00;
            b3 = {1'b0, busy[e]};
            swWr = wbWr && hitEp(epSel, e) && regIdx == REG_EVENT_FLAGS;
            hit = hitEp(usbEp, e);
            next_curBank[e] = curBank[e];
            release_ = swWr && !wb_dat_i[FLAG_BANK_RELEASE]
                && flags[e][FLAG_BANK_RELEASE];
            killNow = cfgDirIn[e] && flags[e][FLAG_OUT_RX];
            dirNow = cfgDirIn[e];
            if (swWr)
            begin
                clr = ~wb_dat_i[7:0] & CLEARABLE;
                if (!cfgDirIn[e])
                begin
                    clr[FLAG_OUT_RX] = !wb_dat_i[FLAG_OUT_RX];
                end
            end
            if (hit && usbNakIn)
            begin
                set[FLAG_NAK_IN] = 1'b1;
            end
            if (hit && usbNakOut)
            begin
                set[FLAG_NAK_OUT] = 1'b1;
            end
            if (hit && (usbStallSent || (usbCrcErr && !cfgDirIn[e]
                && cfgType[e] == EP_ISO)))
            begin
                set[FLAG_STALLED] = 1'b1;
            end
            if (release_ && cfgDirIn[e])
            begin
                b3 = b3 + 3'h1;
                next_curBank[e] = cfgDouble[e] ? !curBank[e] : 1'b0;
                if (cfgDouble[e] && b3 < 3'h2)
                begin
                    set[FLAG_TX_READY] = 1'b1;
                    set[FLAG_BANK_RELEASE] = 1'b1;
                end
            end
            if (release_ && !cfgDirIn[e] && b3 != 3'h0)
            begin
                b3 = b3 - 3'h1;
                next_curBank[e] = cfgDouble[e] ? !curBank[e] : 1'b0;
                if (b3 != 3'h0)
                begin
                    set[FLAG_OUT_RX] = 1'b1;
                    set[FLAG_BANK_RELEASE] = 1'b1;
                end
            end
            if (hit && usbInTaken && cfgDirIn[e] && b3 != 3'h0)
            begin
                b3 = b3 - 3'h1;
                set[FLAG_TX_READY] = 1'b1;
                set[FLAG_BANK_RELEASE] = 1'b1;
            end
            if (killNow && b3 != 3'h0)
            begin
                b3 = b3 - 3'h1;
                set[FLAG_TX_READY] = 1'b1;
                set[FLAG_BANK_RELEASE] = 1'b1;
            end
            if (hit && usbOutDone && !cfgDirIn[e])
            begin
                if (b3 == 3'h0)
                begin
                    set[FLAG_OUT_RX] = 1'b1;
                    set[FLAG_BANK_RELEASE] = 1'b1;
                end
                if (b3 < (cfgDouble[e] ? 3'h2 : 3'h1))
                begin
                    b3 = b3 + 3'h1;
                end
            end
            if (hit && usbSetupDone && !cfgDirIn[e])
            begin
                b3 = 3'h1;
                set[FLAG_SETUP] = 1'b1;
                set[FLAG_BANK_RELEASE] = 1'b1;
            end
            if (wbWr && hitEp(epSel, e) && regIdx == REG_EP_CONFIG)
            begin
                // Mask with the direction being written, or tx-ready is lost.
                dirNow = wb_dat_i[CFG_DIR_IN];
                if (dirNow)
                begin
                    b3 = 3'h0;
                    set[FLAG_TX_READY] = 1'b1;
                    set[FLAG_BANK_RELEASE] = 1'b1;
                end
            end
            next_flags[e] = (flags[e] & ~clr) | set;
            if (dirNow)
            begin
                next_flags[e][FLAG_SETUP] = 1'b0;
                next_flags[e][FLAG_OUT_RX] = swWr && wb_dat_i[FLAG_OUT_RX]
                    && b3 != 3'h0 && !killNow;
            end
            else
            begin
                next_flags[e][FLAG_TX_READY] = 1'b0;
            end
            next_flags[e][FLAG_RW_ALLOWED] = 1'b0;
            next_busy[e] = b3[1:0];
        end
    end

    always_ff @(posedge mclk)
    begin
        for (int e = 0; e < EP_COUNT; e++)
        begin
            if (reset)
            begin
                flags[e] <= FLAGS_RESET;
                busy[e] <= BUSY_NONE;
                curBank[e] <= 1'b0;
            end
            else
            begin
                flags[e] <= next_flags[e];
                busy[e] <= next_busy[e];
                curBank[e] <= next_curBank[e];
            end
        end
    end

    // FIFO pointers; firmware and the link use one pointer pair per endpoint.
    always_ff @(posedge mclk)
    begin
        for (int e = 0; e < EP_COUNT; e++)
        begin
            if (reset)
            begin
                rdPtr[e] <= 8'h00;
                wrPtr[e] <= 8'h00;
            end
            else
            begin
                if ((fwDataRd && hitEp(epSel, e))
                    || (usbTxByte && hitEp(usbEp, e)))
                begin
                    rdPtr[e] <= rdPtr[e] + 8'h01;
                end
                if ((fwDataWr && hitEp(epSel, e))
                    || (usbRxByte && hitEp(usbEp, e)))
                begin
                    wrPtr[e] <= wrPtr[e] + 8'h01;
                end
            end
        end
    end

    usbef_byte_store u_store (
        .mclk(mclk),
        .wrEnA(fwDataWr && cfgDirIn[epSel]),
        .wrAddrA({epSel, wrPtr[epSel]}),
        .wrDataA(wb_dat_i[7:0]),
        .wrEnB(usbRxByte && evValid),
        .wrAddrB({usbEp, wrPtr[usbEp]}),
        .wrDataB(usbRxData),
        .rdAddrA({epSel, rdPtr[epSel]}),
        .rdDataA(fwRdData),
        .rdAddrB({usbEp, rdPtr[usbEp]}),
        .rdDataB(txRdData)
    );

    for (genvar g = 0; g < EP_COUNT; g++)
    begin : g_ep
        usbef_byte_counter u_count (
            .mclk(mclk),
            .reset(reset),
            .countUp((fwDataWr && epSel == 3'(g) && cfgDirIn[g])
                || (usbRxByte && usbEp == 3'(g) && !cfgDirIn[g])),
            .countDown((usbTxByte && usbEp == 3'(g) && cfgDirIn[g])
                || (fwDataRd && epSel == 3'(g) && !cfgDirIn[g])),
            .count(count[g])
        );
        // Not meaningful on control endpoints, so it stays low there.
        assign rwAllowed[g] = cfgType[g] != EP_CONTROL && !stallReq[g]
            && !overflow[g] && !underflow[g] && flags[g][FLAG_BANK_RELEASE]
            && (cfgDirIn[g] || count[g] != '0);
        assign pending[g] = |(flags[g] & enables[g] & EVENT_MASK
            & (cfgDirIn[g] ? 8'hFB : 8'hFF))
            || (enables[g][EN_FLOW_ERROR]
            && (overflow[g] || underflow[g]));
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            usbTxData <= 8'h00;
            endpointIrq <= 1'b0;
        end
        else
        begin
            if (usbTxByte && evValid)
            begin
                usbTxData <= txRdData;
            end
            endpointIrq <= |pending;
        end
    end

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (regIdx)
            REG_EP_SELECT: next_rdata[2:0] = epSel;
            REG_EP_CONFIG: next_rdata[7:0] = {cfgType[epSel],
                1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0}
                | {2'b00, stallReq[epSel], 2'b00, cfgDouble[epSel],
                1'b0, cfgDirIn[epSel]};
            REG_BANK_STATUS: next_rdata[7:0] = {1'b0, overflow[epSel],
                underflow[epSel], 3'b000, busy[epSel]};
            REG_BANK_AUX: next_rdata[2:0] = {control_direction_flag[epSel], 1'b0,
                curBank[epSel]};
            REG_EVENT_FLAGS: next_rdata[7:0] = flags[epSel]
                | {2'b00, rwAllowed[epSel], 5'b00000};
            REG_EVENT_ENABLES: next_rdata[7:0] = enables[epSel];
            REG_FIFO_DATA: next_rdata[7:0] = fwRdData;
            REG_COUNT_HIGH: next_rdata[2:0] = count[epSel][10:8];
            REG_COUNT_LOW: next_rdata[7:0] = count[epSel][7:0];
            REG_PENDING: next_rdata[6:0] = pending;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (req && !wb_ack_o && !wb_we_i)
        begin
            wb_dat_o <= next_rdata;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    property p_busy_legal;
        busy[epSel] != BUSY_RESERVED;
    endproperty
    a_busy_legal: assert property (p_busy_legal)
        else $error("busy bank count shows reserved code");

    property p_nak_in;
        usbNakIn && evValid |=> flags[$past(usbEp)][FLAG_NAK_IN];
    endproperty
    a_nak_in: assert property (p_nak_in)
        else $error("nak in flag not set after nak");

    property p_nak_out;
        usbNakOut && evValid |=> flags[$past(usbEp)][FLAG_NAK_OUT];
    endproperty
    a_nak_out: assert property (p_nak_out)
        else $error("nak out flag not set after nak");

    property p_stalled;
        usbStallSent && evValid |=> flags[$past(usbEp)][FLAG_STALLED];
    endproperty
    a_stalled: assert property (p_stalled)
        else $error("stalled flag not set after stall");

    property p_setup_dir;
        usbSetupDone && usbEp == epSel && !cfgDirIn[epSel]
            ##1 $stable(epSel) |-> control_direction_flag[epSel] == $past(usbSetupDirIn)
            && flags[epSel][FLAG_SETUP] && flags[epSel][FLAG_BANK_RELEASE];
    endproperty
    a_setup_dir: assert property (p_setup_dir)
        else $error("setup did not latch direction and flags");

    property p_rw_stall;
        stallReq[epSel] |-> !rwAllowed[epSel];
    endproperty
    a_rw_stall: assert property (p_rw_stall)
        else $error("rw allowed while stall requested");

    property p_tx_on_out;
        !cfgDirIn[epSel] ##1 !cfgDirIn[epSel] && $stable(epSel)
            |-> !flags[epSel][FLAG_TX_READY];
    endproperty
    a_tx_on_out: assert property (p_tx_on_out)
        else $error("tx ready set on out endpoint");

    property p_irq;
        (|pending) |=> endpointIrq ##0 (!$past(|pending) || endpointIrq);
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq did not follow pending summary");

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("acknowledge held longer than one cycle");
endmodule : usbef_endpoint
`default_nettype wire

/* verification/usbef_host_model.sv */
// Link-side host model that turns event requests into one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module usbef_host_model (
    input wire logic go,
    input wire logic [3:0] kind,
    input wire logic [2:0] ep,
    output logic [2:0] usbEp,
    output logic [10:0] pulses
);
    // Idle cycles carry endpoint 7, so a stale endpoint is never acted on.
    assign usbEp = go ? ep : 3'h7;
    assign pulses = go ? 11'h001 << kind : 11'h000;
endmodule : usbef_host_model
`default_nettype wire

/* verification/usbef_endpoint_test.sv */
// Self-checking bench for the endpoint FIFO and status block.
`timescale 1ns/1ps
`default_nettype none
module usbef_endpoint_test;
    import usbef_pkg::*;
    logic mclk, ack, irq;
    logic reset = 1'b1, cyc = 1'b0, we = 1'b0, go = 1'b0, dirIn = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [31:0] datI = 32'h0, datO;
    logic [3:0] kind = 4'h0;
    logic [2:0] ep = 3'h0, usbEp;
    logic [7:0] rxData = 8'h00, txData, r;
    logic [10:0] pl;
    int miscompares, check_count;
    byte unsigned q[$];
    usbef_host_model u_host (.go(go), .kind(kind), .ep(ep), .usbEp(usbEp),
        .pulses(pl));
    usbef_endpoint u_dut (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .usbEp(usbEp),
        .usbSetupDone(pl[0]), .usbSetupDirIn(dirIn), .usbOutDone(pl[1]),
        .usbInTaken(pl[2]), .usbNakIn(pl[3]), .usbNakOut(pl[4]),
        .usbStallSent(pl[5]), .usbCrcErr(pl[6]), .usbOverflow(pl[7]),
        .usbUnderflow(pl[8]), .usbRxByte(pl[9]), .usbRxData(rxData),
        .usbTxByte(pl[10]), .usbTxData(txData), .endpointIrq(irq));
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    function automatic logic [5:0] ad(input logic [3:0] i);
        return {i, 2'b00};
    endfunction : ad
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask : chk
    // Holds the request until ack is sampled high, then idles one cycle.
    task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        datI <= {24'h000000, d};
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            miscompares++;
            close_out();
        end
        r = datO[7:0];
        cyc <= 1'b0;
        @(posedge mclk);
    endtask : wb
    task automatic host(input logic [3:0] k, input logic [2:0] e);
        kind <= k;
        ep <= e;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        @(negedge mclk);
        r = txData;
        @(posedge mclk);
    endtask : host
    initial
    begin
        r = 8'($urandom(57));
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        wb(0, ad(REG_EVENT_FLAGS), 0);
        chk(r, FLAGS_RESET);
        wb(0, 6'h3C, 0);
        chk(r, 8'h00);
        wb(1, ad(REG_EP_SELECT), 8'h01);
        wb(1, ad(REG_EP_CONFIG), 8'h81);
        wb(0, ad(REG_EVENT_FLAGS), 0);
        chk(r, 8'hA1);
        wb(1, ad(REG_EVENT_ENABLES), 8'h40);
        host(4'd4, 3'd1);
        repeat (2) @(posedge mclk);
        chk({7'h00, irq}, 8'h00);
        host(4'd3, 3'd1);
        wb(0, ad(REG_EVENT_FLAGS), 0);
        chk(r, 8'hF1);
        chk({7'h00, irq}, 8'h01);
        wb(0, ad(REG_PENDING), 0);
        chk(r, 8'h02);
        wb(1, ad(REG_EVENT_FLAGS), 8'hA1);
        repeat (2) @(posedge mclk);
        chk({7'h00, irq}, 8'h00);
        repeat (3)
        begin
            q.push_back(8'($urandom));
            wb(1, ad(REG_FIFO_DATA), q[$]);
        end
        wb(0, ad(REG_COUNT_LOW), 0);
        chk(r, 8'(q.size()));
        wb(0, ad(REG_COUNT_HIGH), 0);
        chk(r, 8'h00);
        while (q.size() > 0)
        begin
            host(4'd10, 3'd1);
            chk(r, q.pop_front());
        end
        wb(0, ad(REG_COUNT_LOW), 0);
        chk(r, 8'h00);
        wb(1, ad(REG_EP_SELECT), 8'h02);
        wb(1, ad(REG_EP_CONFIG), 8'h80);
        repeat (2)
        begin
            q.push_back(8'($urandom));
            rxData <= q[$];
            host(4'd9, 3'd2);
        end
        host(4'd1, 3'd2);
        wb(0, ad(REG_EVENT_FLAGS), 0);
        chk(r, 8'hA4);
        wb(0, ad(REG_BANK_STATUS), 0);
        chk(r & 8'h03, 8'h01);
        while (q.size() > 0)
        begin
            wb(0, ad(REG_FIFO_DATA), 0);
            chk(r, q.pop_front());
        end
        host(4'd5, 3'd2);
        wb(0, ad(REG_EVENT_FLAGS), 0);
        chk(r & 8'h02, 8'h02);
        wb(1, ad(REG_EP_SELECT), 8'h03);
        wb(1, ad(REG_EP_CONFIG), 8'h41);
        host(4'd7, 3'd3);
        wb(0, ad(REG_BANK_STATUS), 0);
        chk(r, 8'h40);
        wb(1, ad(REG_EVENT_ENABLES), 8'h80);
        wb(0, ad(REG_PENDING), 0);
        chk(r, 8'h08);
        wb(1, ad(REG_EVENT_FLAGS), 8'h01);
        wb(0, ad(REG_BANK_STATUS), 0);
        chk(r & 8'h03, 8'h01);
        host(4'd2, 3'd3);
        wb(0, ad(REG_EVENT_FLAGS), 0);
        chk(r, 8'h81);
        wb(1, ad(REG_EVENT_FLAGS), 8'h01);
        wb(1, ad(REG_EVENT_FLAGS), 8'h05);
        wb(0, ad(REG_BANK_STATUS), 0);
        chk(r, 8'h40);
        wb(1, ad(REG_EP_SELECT), 8'h00);
        dirIn <= 1'b1;
        host(4'd0, 3'd0);
        wb(0, ad(REG_EVENT_FLAGS), 0);
        chk(r & 8'hDF, 8'h88);
        wb(1, ad(REG_BANK_AUX), 8'h00);
        wb(0, ad(REG_BANK_AUX), 0);
        chk(r, 8'h04);
        close_out();
    end
endmodule : usbef_endpoint_test
`default_nettype wire
